/* File: pkg/nte_consts.vh */
// Constants for the nibble transfer and exchange unit
`ifndef NTE_CONSTS_VH
`define NTE_CONSTS_VH

// Operation codes on i_op
`define NTE_OP_LD_A_IMM   5'h00
`define NTE_OP_LD_REG_IMM 5'h01
`define NTE_OP_LD_XA_IMM  5'h02
`define NTE_OP_LD_HL_IMM  5'h03
`define NTE_OP_LD_RP2_IMM 5'h04
`define NTE_OP_LD_A_IND   5'h05
`define NTE_OP_LD_XA_HL   5'h06
`define NTE_OP_ST_HL_A    5'h07
`define NTE_OP_ST_HL_XA   5'h08
`define NTE_OP_LD_A_DIR   5'h09
`define NTE_OP_LD_XA_DIR  5'h0a
`define NTE_OP_ST_DIR_A   5'h0b
`define NTE_OP_ST_DIR_XA  5'h0c
`define NTE_OP_MOV_A_REG  5'h0d
`define NTE_OP_MOV_XA_RP  5'h0e
`define NTE_OP_MOV_REG_A  5'h0f
`define NTE_OP_MOV_RP_XA  5'h10
`define NTE_OP_XCH_A_IND  5'h11
`define NTE_OP_XCH_XA_HL  5'h12
`define NTE_OP_XCH_A_DIR  5'h13
`define NTE_OP_XCH_XA_DIR 5'h14
`define NTE_OP_XCH_A_REG  5'h15
`define NTE_OP_XCH_XA_RP  5'h16
`define NTE_OP_OTHER      5'h17

// Pointer choices on i_sel for indirect single-nibble access
`define NTE_PTR_HL        3'h0
`define NTE_PTR_HL_INC    3'h1
`define NTE_PTR_HL_DEC    3'h2
`define NTE_PTR_DE        3'h3
`define NTE_PTR_DL        3'h4

// Single register index on i_sel
`define NTE_REG_X         3'h0
`define NTE_REG_A         3'h1
`define NTE_REG_H         3'h2
`define NTE_REG_L         3'h3
`define NTE_REG_D         3'h4
`define NTE_REG_E         3'h5
`define NTE_REG_B         3'h6
`define NTE_REG_C         3'h7

// Pair index on i_sel: bit 2 selects the alternate bank
`define NTE_RP_XA         3'h0
`define NTE_RP_HL         3'h1
`define NTE_RP_DE         3'h2
`define NTE_RP_BC         3'h3

// Pair choice on i_sel bit 0 for the pointer-pair immediate load
`define NTE_RP2_BC        1'h0
`define NTE_RP2_DE        1'h1

// String groups
`define NTE_GRP_NONE      2'h0
`define NTE_GRP_ACC       2'h1
`define NTE_GRP_PTR       2'h2

// Reset values
`define NTE_NIB_RST       4'h0
`define NTE_BYTE_RST      8'h00

`endif

/* File: core/nte_ptr_step.v */
// Low pointer nibble step and skip decision
`timescale 1ns/10ps
`default_nettype none

module nte_ptr_step (
    input  wire [3:0] i_l,
    input  wire       i_inc,
    input  wire       i_dec,
    output wire [3:0] o_l_nxt,
    output wire       o_skip
);

    wire [4:0] inc_sum;
    wire [4:0] dec_sum;

    assign inc_sum = {1'b0, i_l} + 5'h01;
    assign dec_sum = {1'b0, i_l} + 5'h0f;

    // Step after the access, hold otherwise
    assign o_l_nxt = i_inc ? inc_sum[3:0] :
                     i_dec ? dec_sum[3:0] : i_l;

    // Skip on wrap to zero or to all ones
    assign o_skip = (i_inc & (inc_sum[3:0] == 4'h0)) |
                    (i_dec & (dec_sum[3:0] == 4'hf));

endmodule

`default_nettype wire

/* File: core/nte_core.v */
// Transfer and exchange execution unit of a 4-bit core
`timescale 1ns/10ps
`default_nettype none
`include "nte_consts.vh"

module nte_core (
    input  wire       i_clock,
    input  wire       i_reset_n,
    input  wire       i_exec,
    input  wire [4:0] i_op,
    input  wire [2:0] i_sel,
    input  wire [7:0] i_imm,
    input  wire [3:0] i_mem_rdata,
    output wire       o_busy,
    output wire       o_done,
    output wire       o_skip,
    output wire       o_nop,
    output wire [7:0] o_mem_addr,
    output wire [3:0] o_mem_wdata,
    output wire       o_mem_re,
    output wire       o_mem_we,
    output wire [3:0] o_reg_a,
    output wire [3:0] o_reg_x,
    output wire [3:0] o_reg_h,
    output wire [3:0] o_reg_l,
    output wire [3:0] o_reg_d,
    output wire [3:0] o_reg_e,
    output wire [3:0] o_reg_b,
    output wire [3:0] o_reg_c
);

    ////////////////////////////////////////////////////////////////////
    // States
    localparam [6:0] S_IDLE  = 7'h01;
    localparam [6:0] S_RD_LO = 7'h02;
    localparam [6:0] S_RD_HI = 7'h04;
    localparam [6:0] S_CAP   = 7'h08;
    localparam [6:0] S_WR_LO = 7'h10;
    localparam [6:0] S_WR_HI = 7'h20;
    localparam [6:0] S_END   = 7'h40;

    ////////////////////////////////////////////////////////////////////
    // Storage
    reg  [6:0] state_r;
    reg  [3:0] a_r;
    reg  [3:0] x_r;
    reg  [3:0] h_r;
    reg  [3:0] l_r;
    reg  [3:0] d_r;
    reg  [3:0] e_r;
    reg  [3:0] b_r;
    reg  [3:0] c_r;
    reg  [7:0] alt_r [0:3];
    reg  [1:0] grp_r;
    reg  [4:0] op_r;
    reg  [2:0] sel_r;
    reg  [7:0] base_r;
    reg        pair_r;
    reg        rd_r;
    reg        wb_r;
    reg  [3:0] lo_r;
    reg  [3:0] hi_r;
    reg        busy_r;
    reg        done_r;
    reg        skip_r;
    reg        nop_r;
    reg  [7:0] addr_r;
    reg  [3:0] wdata_r;
    reg        mem_re_r;
    reg        mem_we_r;
    integer    k;

    ////////////////////////////////////////////////////////////////////
    // Decode of the incoming operation
    reg  [7:0] d_base;
    reg        d_pair;
    reg        d_rd;
    reg        d_st;
    reg        d_wb;
    reg  [1:0] d_grp;
    reg  [3:0] reg_rd;
    reg  [7:0] pair_rd;
    wire       ex_go;
    wire       suppress;
    wire       single_wr;
    wire       pair_wr;
    wire [3:0] single_val;
    wire [8:0] base_inc;
    wire       step_inc;
    wire       step_dec;
    wire [3:0] step_l;
    wire       step_skip;
    wire       ind_r;

    assign ex_go    = i_exec & ~busy_r;
    assign base_inc = {1'b0, base_r} + 9'h001;

    always @*
    begin
        d_base = i_imm;
        d_pair = 1'b0;
        d_rd   = 1'b0;
        d_st   = 1'b0;
        d_wb   = 1'b0;
        d_grp  = `NTE_GRP_NONE;
        case (i_op)
            `NTE_OP_LD_A_IMM,
            `NTE_OP_LD_XA_IMM:
                d_grp = `NTE_GRP_ACC;
            `NTE_OP_LD_HL_IMM:
                d_grp = `NTE_GRP_PTR;
            `NTE_OP_LD_A_IND,
            `NTE_OP_XCH_A_IND:
            begin
                d_rd = 1'b1;
                d_wb = (i_op == `NTE_OP_XCH_A_IND);
                case (i_sel)
                    `NTE_PTR_DE: d_base = {d_r, e_r};
                    `NTE_PTR_DL: d_base = {d_r, l_r};
                    default:     d_base = {h_r, l_r};
                endcase
            end
            `NTE_OP_LD_XA_HL,
            `NTE_OP_XCH_XA_HL:
            begin
                d_rd   = 1'b1;
                d_pair = 1'b1;
                d_wb   = (i_op == `NTE_OP_XCH_XA_HL);
                d_base = {h_r, l_r[3:1], 1'b0};
            end
            `NTE_OP_ST_HL_A:
            begin
                d_st   = 1'b1;
                d_base = {h_r, l_r};
            end
            `NTE_OP_ST_HL_XA:
            begin
                d_st   = 1'b1;
                d_pair = 1'b1;
                d_base = {h_r, l_r[3:1], 1'b0};
            end
            `NTE_OP_LD_A_DIR:
                d_rd = 1'b1;
            `NTE_OP_XCH_A_DIR:
            begin
                d_rd = 1'b1;
                d_wb = 1'b1;
            end
            `NTE_OP_LD_XA_DIR,
            `NTE_OP_XCH_XA_DIR:
            begin
                d_rd   = 1'b1;
                d_pair = 1'b1;
                d_wb   = (i_op == `NTE_OP_XCH_XA_DIR);
            end
            `NTE_OP_ST_DIR_A:
                d_st = 1'b1;
            `NTE_OP_ST_DIR_XA:
            begin
                d_st   = 1'b1;
                d_pair = 1'b1;
            end
            default:
                d_grp = `NTE_GRP_NONE;
        endcase
    end

    // Register and pair read ports
    always @*
    begin
        case (i_sel)
            `NTE_REG_X: reg_rd = x_r;
            `NTE_REG_A: reg_rd = a_r;
            `NTE_REG_H: reg_rd = h_r;
            `NTE_REG_L: reg_rd = l_r;
            `NTE_REG_D: reg_rd = d_r;
            `NTE_REG_E: reg_rd = e_r;
            `NTE_REG_B: reg_rd = b_r;
            default:    reg_rd = c_r;
        endcase
        if (i_sel[2])
            pair_rd = alt_r[i_sel[1:0]];
        else
        begin
            case (i_sel[1:0])
                `NTE_RP_XA: pair_rd = {x_r, a_r};
                `NTE_RP_HL: pair_rd = {h_r, l_r};
                `NTE_RP_DE: pair_rd = {d_r, e_r};
                default:    pair_rd = {b_r, c_r};
            endcase
        end
    end

    // Repeat of the previous immediate group is dropped
    assign suppress   = (d_grp != `NTE_GRP_NONE) && (d_grp == grp_r);
    assign single_wr  = (i_op == `NTE_OP_LD_REG_IMM) ||
                        (i_op == `NTE_OP_MOV_REG_A) ||
                        (i_op == `NTE_OP_XCH_A_REG);
    assign pair_wr    = (i_op == `NTE_OP_MOV_RP_XA) ||
                        (i_op == `NTE_OP_XCH_XA_RP);
    assign single_val = (i_op == `NTE_OP_LD_REG_IMM) ? i_imm[3:0] : a_r;

    ////////////////////////////////////////////////////////////////////
    // Pointer stepping
    assign ind_r    = (op_r == `NTE_OP_LD_A_IND) ||
                      (op_r == `NTE_OP_XCH_A_IND);
    assign step_inc = ind_r & (sel_r == `NTE_PTR_HL_INC);
    assign step_dec = ind_r & (sel_r == `NTE_PTR_HL_DEC);

    nte_ptr_step u_step (
        .i_l     (l_r),
        .i_inc   (step_inc),
        .i_dec   (step_dec),
        .o_l_nxt (step_l),
        .o_skip  (step_skip)
    );

    ////////////////////////////////////////////////////////////////////
    // Sequencer and register file
    always @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_r  <= S_IDLE;
            a_r      <= `NTE_NIB_RST;
            x_r      <= `NTE_NIB_RST;
            h_r      <= `NTE_NIB_RST;
            l_r      <= `NTE_NIB_RST;
            d_r      <= `NTE_NIB_RST;
            e_r      <= `NTE_NIB_RST;
            b_r      <= `NTE_NIB_RST;
            c_r      <= `NTE_NIB_RST;
            for (k = 0; k < 4; k = k + 1)
                alt_r[k] <= `NTE_BYTE_RST;
            grp_r    <= `NTE_GRP_NONE;
            op_r     <= `NTE_OP_OTHER;
            sel_r    <= 3'h0;
            base_r   <= `NTE_BYTE_RST;
            pair_r   <= 1'b0;
            rd_r     <= 1'b0;
            wb_r     <= 1'b0;
            lo_r     <= `NTE_NIB_RST;
            hi_r     <= `NTE_NIB_RST;
            busy_r   <= 1'b0;
            done_r   <= 1'b0;
            skip_r   <= 1'b0;
            nop_r    <= 1'b0;
            addr_r   <= `NTE_BYTE_RST;
            wdata_r  <= `NTE_NIB_RST;
            mem_re_r <= 1'b0;
            mem_we_r <= 1'b0;
        end
        else
        begin
            done_r <= 1'b0;
            skip_r <= 1'b0;
            nop_r  <= 1'b0;
            case (state_r)
                S_IDLE:
                begin
                    if (ex_go)
                    begin
                        grp_r  <= d_grp;
                        op_r   <= i_op;
                        sel_r  <= i_sel;
                        base_r <= d_base;
                        pair_r <= d_pair;
                        rd_r   <= d_rd;
                        wb_r   <= d_wb;
                        if (suppress)
                        begin
                            done_r <= 1'b1;
                            nop_r  <= 1'b1;
                        end
                        else if (d_rd)
                        begin
                            mem_re_r <= 1'b1;
                            addr_r   <= d_base;
                            busy_r   <= 1'b1;
                            state_r  <= S_RD_LO;
                        end
                        else if (d_st)
                        begin
                            mem_we_r <= 1'b1;
                            addr_r   <= d_base;
                            wdata_r  <= a_r;
                            busy_r   <= 1'b1;
                            state_r  <= S_WR_LO;
                        end
                        else
                        begin
                            done_r <= 1'b1;
                            case (i_op)
                                `NTE_OP_LD_A_IMM:
                                    a_r <= i_imm[3:0];
                                `NTE_OP_LD_XA_IMM:
                                    {x_r, a_r} <= i_imm;
                                `NTE_OP_LD_HL_IMM:
                                    {h_r, l_r} <= i_imm;
                                `NTE_OP_LD_RP2_IMM:
                                begin
                                    if (i_sel[0] == `NTE_RP2_DE)
                                        {d_r, e_r} <= i_imm;
                                    else
                                        {b_r, c_r} <= i_imm;
                                end
                                `NTE_OP_MOV_A_REG,
                                `NTE_OP_XCH_A_REG:
                                    a_r <= reg_rd;
                                `NTE_OP_MOV_XA_RP,
                                `NTE_OP_XCH_XA_RP:
                                    {x_r, a_r} <= pair_rd;
                                default:
                                    a_r <= a_r;
                            endcase
                            if (single_wr)
                            begin
                                case (i_sel)
                                    `NTE_REG_X: x_r <= single_val;
                                    `NTE_REG_H: h_r <= single_val;
                                    `NTE_REG_L: l_r <= single_val;
                                    `NTE_REG_D: d_r <= single_val;
                                    `NTE_REG_E: e_r <= single_val;
                                    `NTE_REG_B: b_r <= single_val;
                                    `NTE_REG_C: c_r <= single_val;
                                    default:    x_r <= x_r;
                                endcase
                            end
                            if (pair_wr)
                            begin
                                if (i_sel[2])
                                    alt_r[i_sel[1:0]] <= {x_r, a_r};
                                else
                                begin
                                    case (i_sel[1:0])
                                        `NTE_RP_HL: {h_r, l_r} <= {x_r, a_r};
                                        `NTE_RP_DE: {d_r, e_r} <= {x_r, a_r};
                                        `NTE_RP_BC: {b_r, c_r} <= {x_r, a_r};
                                        default:    h_r <= h_r;
                                    endcase
                                end
                            end
                        end
                    end
                end
                S_RD_LO:
                begin
                    if (pair_r)
                    begin
                        addr_r  <= base_inc[7:0];
                        state_r <= S_RD_HI;
                    end
                    else
                    begin
                        mem_re_r <= 1'b0;
                        state_r  <= S_CAP;
                    end
                end
                S_RD_HI:
                begin
                    lo_r     <= i_mem_rdata;
                    mem_re_r <= 1'b0;
                    state_r  <= S_CAP;
                end
                S_CAP:
                begin
                    if (pair_r)
                        hi_r <= i_mem_rdata;
                    else
                        lo_r <= i_mem_rdata;
                    if (wb_r)
                    begin
                        mem_we_r <= 1'b1;
                        addr_r   <= base_r;
                        wdata_r  <= a_r;
                        state_r  <= S_WR_LO;
                    end
                    else
                        state_r <= S_END;
                end
                S_WR_LO:
                begin
                    if (pair_r)
                    begin
                        addr_r  <= base_inc[7:0];
                        wdata_r <= x_r;
                        state_r <= S_WR_HI;
                    end
                    else
                    begin
                        mem_we_r <= 1'b0;
                        state_r  <= S_END;
                    end
                end
                S_WR_HI:
                begin
                    mem_we_r <= 1'b0;
                    state_r  <= S_END;
                end
                S_END:
                begin
                    // All register effects land on this one edge
                    if (rd_r)
                        a_r <= lo_r;
                    if (rd_r && pair_r)
                        x_r <= hi_r;
                    l_r     <= step_l;
                    skip_r  <= step_skip;
                    done_r  <= 1'b1;
                    busy_r  <= 1'b0;
                    state_r <= S_IDLE;
                end
                default:
                begin
                    mem_re_r <= 1'b0;
                    mem_we_r <= 1'b0;
                    busy_r   <= 1'b0;
                    state_r  <= S_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign o_busy      = busy_r;
    assign o_done      = done_r;
    assign o_skip      = skip_r;
    assign o_nop       = nop_r;
    assign o_mem_addr  = addr_r;
    assign o_mem_wdata = wdata_r;
    assign o_mem_re    = mem_re_r;
    assign o_mem_we    = mem_we_r;
    assign o_reg_a     = a_r;
    assign o_reg_x     = x_r;
    assign o_reg_h     = h_r;
    assign o_reg_l     = l_r;
    assign o_reg_d     = d_r;
    assign o_reg_e     = e_r;
    assign o_reg_b     = b_r;
    assign o_reg_c     = c_r;

endmodule

`default_nettype wire

/* File: dv/nte_core_properties.sv */
// Port-level checker for the transfer and exchange unit
`timescale 1ns/10ps
`default_nettype none
`include "nte_consts.vh"
module nte_core_properties (
    input wire logic       i_clock,
    input wire logic       i_reset_n,
    input wire logic       i_exec,
    input wire logic [4:0] i_op,
    input wire logic [7:0] i_imm,
    input wire logic       o_busy,
    input wire logic       o_done,
    input wire logic       o_skip,
    input wire logic       o_nop,
    input wire logic [7:0] o_mem_addr,
    input wire logic [3:0] o_mem_wdata,
    input wire logic       o_mem_re,
    input wire logic       o_mem_we,
    input wire logic [3:0] o_reg_a,
    input wire logic [3:0] o_reg_x,
    input wire logic [3:0] o_reg_h,
    input wire logic [3:0] o_reg_l
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    wire take = i_exec && !o_busy;
    wire [6:0] base = {o_reg_h, o_reg_l[3:1]};
    // Two reads, even address first
    sequence pair_rd;
        o_mem_re && o_mem_addr == {base, 1'b0}
        ##1 o_mem_re && o_mem_addr == {base, 1'b1};
    endsequence
    nop_hold_a: assert property (o_nop |-> o_done && $stable(o_reg_a) &&
        $stable(o_reg_x) && $stable(o_reg_h) && $stable(o_reg_l))
        else $error("dropped load changed a register");
    skip_wrap_a: assert property (o_skip |-> o_done &&
        (o_reg_l == 4'h0 || o_reg_l == 4'hf)) else $error("bad skip");
    imm_load_a: assert property (take && i_op == `NTE_OP_LD_A_IMM |=>
        o_done && (o_nop || {4'h0, o_reg_a} == ($past(i_imm) & 8'h0f)))
        else $error("immediate load wrong");
    st_single_a: assert property (take && i_op == `NTE_OP_ST_HL_A |=>
        o_mem_we && o_mem_addr == {o_reg_h, o_reg_l} &&
        o_mem_wdata == o_reg_a ##2 o_done) else $error("store wrong");
    dir_load_a: assert property (take && i_op == `NTE_OP_LD_A_DIR |=>
        o_mem_re && o_mem_addr == $past(i_imm) ##3 o_done)
        else $error("direct read address wrong");
    pair_load_a: assert property (take && i_op == `NTE_OP_LD_XA_HL |=>
        pair_rd ##3 o_done) else $error("pair read wrong");
    we_busy_a: assert property (o_mem_we |-> o_busy)
        else $error("write outside busy");
    busy_end_a: assert property ($fell(o_busy) |-> o_done)
        else $error("busy ended without done");
    rw_excl_a: assert property (!(o_mem_re && o_mem_we))
        else $error("read and write together");
endmodule
bind nte_core nte_core_properties u_props (.i_clock, .i_reset_n, .i_exec,
    .i_op, .i_imm, .o_busy, .o_done, .o_skip, .o_nop, .o_mem_addr,
    .o_mem_wdata, .o_mem_re, .o_mem_we, .o_reg_a, .o_reg_x, .o_reg_h,
    .o_reg_l);
`default_nettype wire

/* File: dv/nte_mem_model.sv */
// Nibble data memory with synchronous read
`timescale 1ns/10ps
`default_nettype none
module nte_mem_model (
    input  wire logic       i_clock,
    input  wire logic [7:0] i_addr,
    input  wire logic [3:0] i_wdata,
    input  wire logic       i_re,
    input  wire logic       i_we,
    output var  logic [3:0] o_rdata
);
    logic [3:0] m [0:255];
    initial
    begin
        o_rdata = 4'h0;
        for (int i = 0; i < 256; i++) m[i] = 4'h0;
    end
    // Data the cycle after the read; inverted when not read
    always @(posedge i_clock)
    begin
        if (i_we) m[i_addr] <= i_wdata;
        o_rdata <= i_re ? m[i_addr] : ~o_rdata;
    end
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench for the transfer and exchange unit
`timescale 1ns/10ps
`default_nettype none
`include "nte_consts.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
    $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb;
    logic clk = 0, rst_n = 0, ex = 0, sk, np;
    logic [4:0] op = 0;
    logic [2:0] sel = 0;
    logic [7:0] imm = 0, addr;
    logic [3:0] rd, wd, a, x, h, l, d, e, b, c;
    logic busy, done, skip, nop, re, we;
    int n_fail = 0, tests_run = 0;
    initial forever #2.5 clk = ~clk;
    nte_mem_model mem (.i_clock(clk), .i_addr(addr), .i_wdata(wd),
        .i_re(re), .i_we(we), .o_rdata(rd));
    nte_core uut (.i_clock(clk), .i_reset_n(rst_n), .i_exec(ex), .i_op(op),
        .i_sel(sel), .i_imm(imm), .i_mem_rdata(rd), .o_busy(busy),
        .o_done(done), .o_skip(skip), .o_nop(nop), .o_mem_addr(addr),
        .o_mem_wdata(wd), .o_mem_re(re), .o_mem_we(we), .o_reg_a(a),
        .o_reg_x(x), .o_reg_h(h), .o_reg_l(l), .o_reg_d(d), .o_reg_e(e),
        .o_reg_b(b), .o_reg_c(c));
    task end_of_test;
        $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // One instruction, bounded wait for done
    task run(input logic [4:0] o, input logic [2:0] s, input logic [7:0] i);
        int k;
        @(posedge clk);
        #1 ex = 1; op = o; sel = s; imm = i;
        @(posedge clk);
        #1 ex = 0;
        for (k = 0; k < 20 && done !== 1'b1; k++)
        begin
            @(posedge clk);
            #1;
        end
        if (done !== 1'b1)
        begin
            n_fail++;
            end_of_test;
        end
        sk = skip;
        np = nop;
    endtask
    task t_imm;
        run(`NTE_OP_LD_A_IMM, 0, 8'h0b);
        `CHK({np, a}, 5'h0b)
        run(`NTE_OP_LD_XA_IMM, 0, 8'h5c);
        `CHK({np, x, a}, 9'h10b)
        run(`NTE_OP_OTHER, 0, 0);
        run(`NTE_OP_LD_XA_IMM, 0, 8'h5c);
        `CHK({np, x, a}, 9'h05c)
        for (int i = 0; i < 8; i++)
            if (i != 1) run(`NTE_OP_LD_REG_IMM, i, 8'h08 + i);
        `CHK({x, h, l, d, e, b, c}, 28'h8abcdef)
        $display("t_imm done");
    endtask
    task t_ptr;
        run(`NTE_OP_LD_HL_IMM, 0, 8'h3f);
        run(`NTE_OP_LD_HL_IMM, 0, 8'h12);
        `CHK({np, h, l}, 9'h13f)
        run(`NTE_OP_LD_RP2_IMM, 1, 8'h9a);
        run(`NTE_OP_LD_RP2_IMM, 1, 8'h87);
        run(`NTE_OP_LD_RP2_IMM, 0, 8'h65);
        `CHK({np, d, e, b, c}, 17'h08765)
        $display("t_ptr done");
    endtask
    task t_mem;
        mem.m[8'h3e] = 4'h1;
        mem.m[8'h3f] = 4'h2;
        mem.m[8'h30] = 4'h7;
        run(`NTE_OP_LD_XA_HL, 0, 0);
        `CHK({x, a}, 8'h21)
        run(`NTE_OP_LD_A_IND, `NTE_PTR_HL_INC, 0);
        `CHK({sk, a, l}, 9'h120)
        run(`NTE_OP_LD_A_IND, `NTE_PTR_HL_DEC, 0);
        `CHK({sk, a, l}, 9'h17f)
        $display("t_mem done");
    endtask
    task t_dir;
        mem.m[8'hff] = 4'h4;
        run(`NTE_OP_ST_DIR_XA, 0, 8'h40);
        `CHK({mem.m[8'h41], mem.m[8'h40]}, 8'h27)
        run(`NTE_OP_LD_A_DIR, 0, 8'hff);
        `CHK(a, 4'h4)
        run(`NTE_OP_ST_HL_A, 0, 0);
        `CHK(mem.m[8'h3f], 4'h4)
        $display("t_dir done");
    endtask
    task t_xch;
        run(`NTE_OP_LD_REG_IMM, `NTE_REG_X, 8'h09);
        run(`NTE_OP_XCH_XA_DIR, 0, 8'h40);
        `CHK({x, a, mem.m[8'h41], mem.m[8'h40]}, 16'h2794)
        run(`NTE_OP_XCH_A_REG, `NTE_REG_B, 0);
        `CHK({a, b}, 8'h67)
        run(`NTE_OP_MOV_RP_XA, 3'h4, 0);
        run(`NTE_OP_LD_XA_IMM, 0, 8'h00);
        run(`NTE_OP_MOV_XA_RP, 3'h4, 0);
        `CHK({x, a}, 8'h26)
        run(`NTE_OP_MOV_A_REG, `NTE_REG_H, 0);
        `CHK(a, 4'h3)
        run(`NTE_OP_XCH_A_IND, `NTE_PTR_HL_INC, 0);
        `CHK({sk, a, l, mem.m[8'h3f]}, 13'h1403)
        $display("t_xch done");
    endtask
    task t_more;
        mem.m[8'h87] = 4'h9;
        mem.m[8'h81] = 4'h6;
        run(`NTE_OP_ST_HL_XA, 0, 0);
        `CHK({mem.m[8'h31], mem.m[8'h30]}, 8'h24)
        run(`NTE_OP_LD_REG_IMM, `NTE_REG_L, 8'h01);
        run(`NTE_OP_LD_REG_IMM, `NTE_REG_X, 8'h05);
        run(`NTE_OP_LD_A_IMM, 0, 8'h0c);
        run(`NTE_OP_XCH_XA_HL, 0, 0);
        `CHK({x, a, mem.m[8'h31], mem.m[8'h30]}, 16'h245c)
        run(`NTE_OP_LD_XA_DIR, 0, 8'h30);
        `CHK({x, a}, 8'h5c)
        run(`NTE_OP_LD_A_IND, `NTE_PTR_DE, 0);
        `CHK({sk, a}, 5'h09)
        run(`NTE_OP_LD_A_IND, `NTE_PTR_DL, 0);
        `CHK({sk, a}, 5'h06)
        run(`NTE_OP_MOV_REG_A, `NTE_REG_E, 0);
        `CHK(e, 4'h6)
        run(`NTE_OP_XCH_XA_RP, `NTE_RP_BC, 0);
        `CHK({x, a, b, c}, 16'h7556)
        $display("t_more done");
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        #1 rst_n = 1;
        t_imm;
        t_ptr;
        t_mem;
        t_dir;
        t_xch;
        t_more;
        end_of_test;
    end
endmodule
`default_nettype wire
